/* include/fwpg_pkg.sv */
// fwpg_pkg: shared constants, command enum and carrier structs for the
// flash write protection gating controller.
// assumes a 16-bit word-mode NOR flash with 21 word address lines.
package fwpg_pkg;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_CMD    = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_RDATA  = 3'h5;

  localparam int CTRL_WP_BIT  = 0;
  localparam int CTRL_HV_BIT  = 1;
  localparam int CTRL_TOP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  localparam int ST_BUSY   = 0;
  localparam int ST_SECURE = 1;
  localparam int ST_ERR    = 2;
  localparam int ST_PWR    = 3;
  localparam int ST_SUPPLY = 4;

  // ----------------------------------------------------------------
  // commands and bus codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ, CMD_PROG, CMD_ERASE, CMD_ENTER, CMD_EXIT, CMD_LOCK, CMD_HWRST
  } fwpg_cmd_type;
  localparam logic [2:0] CMD_LAST = 3'h6;

  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
  localparam logic [DATA_W-1:0] PROG_CODE = 16'h00a0;
  localparam logic [DATA_W-1:0] ERASE_CODE = 16'h0080;
  localparam logic [DATA_W-1:0] ERASE_CONF = 16'h0030;
  localparam logic [DATA_W-1:0] ENTER_CODE = 16'h0088;
  localparam logic [DATA_W-1:0] EXIT_CODE  = 16'h0090;
  localparam logic [DATA_W-1:0] EXIT_CONF  = 16'h0000;
  localparam logic [DATA_W-1:0] LOCK_CODE  = 16'h0060;

  // ----------------------------------------------------------------
  // address windows (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BOT_PAIR_END = 21'h001fff; // two 8 Kbyte sectors
  localparam logic [ADDR_W-1:0] TOP_PAIR_BASE = 21'h1fe000;
  localparam logic [ADDR_W-1:0] BOT_SEC_END  = 21'h007fff; // 64 Kbyte secure region
  localparam logic [ADDR_W-1:0] TOP_SEC_BASE = 21'h1f8000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int WE_LOW_NS    = 30;
  localparam int WE_CYC       = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_NS      = 120;
  localparam int READ_CYC     = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_NS   = 500;
  localparam int RST_CYC      = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_NS    = 100;
  localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POWERUP_US   = 50;
  localparam int POWERUP_CYC  = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fwpg_cyc_type;

  typedef struct packed {
    fwpg_cyc_type cyc;
    logic         last;
  } fwpg_step_type;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } fwpg_pins_type;

  localparam fwpg_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                          addr: '0, dq_out: '0, dq_oe: 1'b0};

endpackage

/* design/fwpg_cycle.sv */
// fwpg_cycle: runs one asynchronous flash bus cycle, write or read.
// assumes the dq input comes straight from the pins of the flash.
`timescale 1ns/10ps
module fwpg_cycle
#(
  parameter int WE_CYC   = fwpg_pkg::WE_CYC,
  parameter int READ_CYC = fwpg_pkg::READ_CYC
)
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    go,
  input  wire fwpg_pkg::fwpg_cyc_type  req,
  input  wire logic [15:0]             dq_in,
  output fwpg_pkg::fwpg_pins_type      pins,
  output logic                         done,
  output logic [15:0]                  rdata
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fwpg_eng_type;

  localparam int CW = $clog2(READ_CYC + 3);

  fwpg_eng_type   st_r;
  logic [CW-1:0]  cnt_r;
  logic           wr_r;
  logic [15:0]    dq_s1_r;
  logic [15:0]    dq_s2_r;

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  // two flops before the data is read
  always_ff @(posedge mclk)
  begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // ce low first, then a single strobe, then release; oe held high on writes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r  <= E_IDLE;
      cnt_r <= '0;
      wr_r  <= 1'b0;
      pins  <= fwpg_pkg::PINS_IDLE;
      done  <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      done <= 1'b0;
      case (st_r)
        E_IDLE:
        begin
          if (go)
          begin
            pins.ce_n   <= 1'b0;
            pins.addr   <= req.addr;
            pins.dq_out <= req.data;
            pins.dq_oe  <= req.wr;
            wr_r        <= req.wr;
            st_r        <= E_SETUP;
          end
        end
        E_SETUP:
        begin
          if (wr_r)
          begin
            pins.we_n <= 1'b0;
            cnt_r     <= CW'(WE_CYC - 1);
          end
          else
          begin
            pins.oe_n <= 1'b0;
            cnt_r     <= CW'(READ_CYC + 1); // access time plus sync delay
          end
          st_r <= E_STROBE;
        end
        E_STROBE:
        begin
          if (cnt_r == '0)
          begin
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!wr_r)
              rdata <= dq_s2_r;
            st_r <= E_HOLD;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        E_HOLD:
        begin
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
          st_r       <= E_IDLE;
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end

  a_write_window: assert property (@(posedge mclk) disable iff (sys_rst)
    !pins.we_n |-> (!pins.ce_n && pins.oe_n && pins.dq_oe))
    else $error("we low without ce low and oe high");

  a_we_pulse_width: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("we low pulse not three cycles");

  a_oe_we_apart: assert property (@(posedge mclk) disable iff (sys_rst)
    !(!pins.oe_n && !pins.we_n))
    else $error("oe and we low together");

endmodule

/* design/fwpg_ctrl.sv */
// fwpg_ctrl: host side controller that drives a dual-bank NOR flash and
// keeps program and erase within the flash's write protection scheme.
// assumes an external level shifter raises the reset pin when hv_en is high
// and a supply comparator reports the lockout level.
//
// How it works
// - after enter sequence, secure region locks with reset pin high or elevated.
// - host issues exit sequence before touching the rest of the array.
// - program and erase need the unlock cycles first.
// - writes need chip and write enable low with output enable high.
`timescale 1ns/10ps
module fwpg_ctrl
#(
  parameter int POWERUP_CYC = fwpg_pkg::POWERUP_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic [20:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_rst_n,
  output logic             flash_hv_en,
  output logic             write_protect_accel_pin,
  input  wire logic        flash_busy_n,
  input  wire logic        supply_above_lockout
);

  typedef enum logic [2:0] {
    T_POWERUP, T_IDLE, T_ISSUE, T_WAIT, T_SETTLE, T_POLL, T_RST
  } fwpg_seq_type;

  localparam int PW = $clog2(POWERUP_CYC + 1);

  fwpg_seq_type             st_r;
  logic [PW-1:0]            cnt_r;
  logic [2:0]               ctrl_r;
  logic [20:0]              addr_r;
  logic [15:0]              wdata_r;
  fwpg_pkg::fwpg_cmd_type   cmd_r;
  logic [2:0]               step_r;
  logic                     err_r;
  logic                     secure_r;
  logic                     pwr_done_r;
  logic                     rst_pin_r;
  logic                     busy_s1_r;
  logic                     busy_s2_r;
  logic                     sup_s1_r;
  logic                     sup_s2_r;
  logic                     go;
  logic                     eng_done;
  logic [15:0]              eng_rdata;
  fwpg_pkg::fwpg_pins_type  pins;
  fwpg_pkg::fwpg_step_type  step;
  fwpg_pkg::fwpg_cmd_type   new_cmd;
  logic                     cmd_wr;
  logic                     in_pair;
  logic                     in_sec;
  logic                     refuse;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  // two flops each for the ready line and the supply comparator
  always_ff @(posedge mclk)
  begin
    busy_s1_r <= flash_busy_n;
    busy_s2_r <= busy_s1_r;
    sup_s1_r  <= supply_above_lockout;
    sup_s2_r  <= sup_s1_r;
  end

  // ----------------------------------------------------------------
  // command steps
  // ----------------------------------------------------------------
  // bus cycle for a given command and step; unlock pair leads every write command
  function automatic fwpg_pkg::fwpg_step_type step_of(input fwpg_pkg::fwpg_cmd_type c,
                                                      input logic [2:0] s,
                                                      input logic [20:0] a,
                                                      input logic [15:0] d);
    fwpg_pkg::fwpg_step_type r;
    r = '{cyc: '{wr: 1'b1, addr: fwpg_pkg::UNLOCK_A1, data: fwpg_pkg::UNLOCK_D1}, last: 1'b0};
    case ({c, s})
      {fwpg_pkg::CMD_READ, 3'h0}:  r = '{cyc: '{wr: 1'b0, addr: a, data: '0}, last: 1'b1};
      {fwpg_pkg::CMD_PROG, 3'h1},
      {fwpg_pkg::CMD_ERASE, 3'h1},
      {fwpg_pkg::CMD_ERASE, 3'h4},
      {fwpg_pkg::CMD_ENTER, 3'h1},
      {fwpg_pkg::CMD_EXIT, 3'h1},
      {fwpg_pkg::CMD_LOCK, 3'h1}:  r.cyc = '{wr: 1'b1, addr: fwpg_pkg::UNLOCK_A2,
                                              data: fwpg_pkg::UNLOCK_D2};
      {fwpg_pkg::CMD_PROG, 3'h2}:  r.cyc.data = fwpg_pkg::PROG_CODE;
      {fwpg_pkg::CMD_PROG, 3'h3}:  r = '{cyc: '{wr: 1'b1, addr: a, data: d}, last: 1'b1};
      {fwpg_pkg::CMD_ERASE, 3'h2}: r.cyc.data = fwpg_pkg::ERASE_CODE;
      {fwpg_pkg::CMD_ERASE, 3'h5}: r = '{cyc: '{wr: 1'b1, addr: a, data: fwpg_pkg::ERASE_CONF},
                                         last: 1'b1};
      {fwpg_pkg::CMD_ENTER, 3'h2}: r = '{cyc: '{wr: 1'b1, addr: fwpg_pkg::UNLOCK_A1,
                                              data: fwpg_pkg::ENTER_CODE}, last: 1'b1};
      {fwpg_pkg::CMD_EXIT, 3'h2}:  r.cyc.data = fwpg_pkg::EXIT_CODE;
      {fwpg_pkg::CMD_EXIT, 3'h3}:  r = '{cyc: '{wr: 1'b1, addr: fwpg_pkg::UNLOCK_A1,
                                              data: fwpg_pkg::EXIT_CONF}, last: 1'b1};
      {fwpg_pkg::CMD_LOCK, 3'h2}:  r = '{cyc: '{wr: 1'b1, addr: a, data: fwpg_pkg::LOCK_CODE},
                                         last: 1'b1};
      default: ;
    endcase
    return r;
  endfunction

  assign step = step_of(cmd_r, step_r, addr_r, wdata_r);

  // ----------------------------------------------------------------
  // command gating
  // ----------------------------------------------------------------
  // refuse what the flash would drop or what would break the secure mapping
  assign cmd_wr  = reg_wr && (reg_addr == fwpg_pkg::REG_CMD);
  assign new_cmd = fwpg_pkg::fwpg_cmd_type'(reg_wdata[2:0]);
  assign in_pair = ctrl_r[fwpg_pkg::CTRL_TOP_BIT] ? (addr_r >= fwpg_pkg::TOP_PAIR_BASE)
                                                  : (addr_r <= fwpg_pkg::BOT_PAIR_END);
  assign in_sec  = ctrl_r[fwpg_pkg::CTRL_TOP_BIT] ? (addr_r >= fwpg_pkg::TOP_SEC_BASE)
                                                  : (addr_r <= fwpg_pkg::BOT_SEC_END);

  always_comb
  begin
    refuse = (st_r != T_IDLE) || !pwr_done_r || !sup_s2_r;
    if (reg_wdata[2:0] > fwpg_pkg::CMD_LAST)
      refuse = 1'b1;
    else if ((new_cmd == fwpg_pkg::CMD_PROG || new_cmd == fwpg_pkg::CMD_ERASE) &&
             !secure_r && in_pair && !ctrl_r[fwpg_pkg::CTRL_WP_BIT])
      refuse = 1'b1;
    else if (secure_r && !in_sec && (new_cmd == fwpg_pkg::CMD_READ ||
             new_cmd == fwpg_pkg::CMD_PROG || new_cmd == fwpg_pkg::CMD_ERASE))
      refuse = 1'b1;
    else if ((new_cmd == fwpg_pkg::CMD_LOCK || new_cmd == fwpg_pkg::CMD_EXIT) && !secure_r)
      refuse = 1'b1;
    else if (new_cmd == fwpg_pkg::CMD_ENTER && secure_r)
      refuse = 1'b1;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // control, address, data and last command result
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_r  <= fwpg_pkg::CTRL_RESET;
      addr_r  <= '0;
      wdata_r <= '0;
      err_r   <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == fwpg_pkg::REG_CTRL)
        ctrl_r <= reg_wdata[2:0];
      if (reg_wr && reg_addr == fwpg_pkg::REG_ADDR)
        addr_r <= reg_wdata[20:0];
      if (reg_wr && reg_addr == fwpg_pkg::REG_WDATA)
        wdata_r <= reg_wdata[15:0];
      if (cmd_wr)
        err_r <= refuse;
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
      case (reg_addr)
        fwpg_pkg::REG_CTRL:   reg_rdata <= {29'h0, ctrl_r};
        fwpg_pkg::REG_ADDR:   reg_rdata <= {11'h0, addr_r};
        fwpg_pkg::REG_WDATA:  reg_rdata <= {16'h0, wdata_r};
        fwpg_pkg::REG_CMD:    reg_rdata <= {29'h0, cmd_r};
        fwpg_pkg::REG_STATUS: reg_rdata <= {27'h0, sup_s2_r, pwr_done_r, err_r, secure_r,
                                            st_r != T_IDLE};
        fwpg_pkg::REG_RDATA:  reg_rdata <= {16'h0, eng_rdata};
        default:              reg_rdata <= '0;
      endcase
    else
      reg_rdata <= '0;
  end

  // ----------------------------------------------------------------
  // secure region mapping tracker
  // ----------------------------------------------------------------
  // mapping set by the enter sequence, dropped by exit, reset or supply loss
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !sup_s2_r || st_r == T_RST)
      secure_r <= 1'b0;
    else if (eng_done && step.last && cmd_r == fwpg_pkg::CMD_ENTER)
      secure_r <= 1'b1;
    else if (eng_done && step.last && cmd_r == fwpg_pkg::CMD_EXIT)
      secure_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // power-up hold, then one command at a time, polling ready after program, erase and lock
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r       <= T_POWERUP;
      cnt_r      <= '0;
      cmd_r      <= fwpg_pkg::CMD_READ;
      step_r     <= '0;
      go         <= 1'b0;
      pwr_done_r <= 1'b0;
      rst_pin_r  <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      case (st_r)
        T_POWERUP, T_RST:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == PW'(fwpg_pkg::RST_CYC - 1))
            rst_pin_r <= 1'b1;
          if ((st_r == T_RST && cnt_r == PW'(fwpg_pkg::RST_CYC)) ||
              cnt_r == PW'(POWERUP_CYC - 1))
          begin
            pwr_done_r <= 1'b1;
            st_r       <= T_IDLE;
          end
        end
        T_IDLE:
        begin
          cnt_r  <= '0;
          step_r <= '0;
          if (cmd_wr && !refuse)
          begin
            cmd_r <= new_cmd;
            if (new_cmd == fwpg_pkg::CMD_HWRST)
            begin
              rst_pin_r <= 1'b0;
              st_r      <= T_RST;
            end
            else
            begin
              go   <= 1'b1;
              st_r <= T_WAIT;
            end
          end
        end
        T_ISSUE:
        begin
          go   <= 1'b1;
          st_r <= T_WAIT;
        end
        T_WAIT:
        begin
          if (eng_done && !step.last)
          begin
            step_r <= step_r + 1'b1;
            st_r   <= T_ISSUE;
          end
          else if (eng_done && cmd_r inside {fwpg_pkg::CMD_PROG, fwpg_pkg::CMD_ERASE,
                                             fwpg_pkg::CMD_LOCK})
            st_r <= T_SETTLE;
          else if (eng_done)
            st_r <= T_IDLE;
        end
        T_SETTLE:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == PW'(fwpg_pkg::SETTLE_CYC - 1))
            st_r <= T_POLL;
        end
        T_POLL:
        begin
          if (busy_s2_r)
            st_r <= T_IDLE;
        end
        default: st_r <= T_IDLE;
      endcase
    end
  end

  fwpg_cycle u_cycle (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .go      (go),
    .req     (step.cyc),
    .dq_in   (flash_dq_in),
    .pins    (pins),
    .done    (eng_done),
    .rdata   (eng_rdata)
  );

  // pins straight from the engine and control flops
  assign flash_ce_n              = pins.ce_n;
  assign flash_oe_n              = pins.oe_n;
  assign flash_we_n              = pins.we_n;
  assign flash_addr              = pins.addr;
  assign flash_dq_out            = pins.dq_out;
  assign flash_dq_oe             = pins.dq_oe;
  assign flash_rst_n             = rst_pin_r;
  assign flash_hv_en             = ctrl_r[fwpg_pkg::CTRL_HV_BIT];
  assign write_protect_accel_pin = ctrl_r[fwpg_pkg::CTRL_WP_BIT];

  a_powerup_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !pwr_done_r |-> (flash_we_n && flash_ce_n && st_r == T_POWERUP))
    else $error("flash strobed during power-up");

  a_wp_pin_track: assert property (@(posedge mclk) disable iff (sys_rst)
    (reg_wr && reg_addr == fwpg_pkg::REG_CTRL) |=>
      write_protect_accel_pin == $past(reg_wdata[0]))
    else $error("write protect pin not following control");

  a_boot_refused: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd_wr && st_r == T_IDLE && new_cmd == fwpg_pkg::CMD_PROG && in_pair && !secure_r &&
     !write_protect_accel_pin) |=> (err_r && st_r == T_IDLE && flash_we_n))
    else $error("boot pair write issued with protect low");

  a_unlock_lead: assert property (@(posedge mclk) disable iff (sys_rst)
    (go && step_r == 3'h0 && cmd_r != fwpg_pkg::CMD_READ) |->
      (step.cyc.addr == fwpg_pkg::UNLOCK_A1 && step.cyc.data == fwpg_pkg::UNLOCK_D1))
    else $error("write command without leading unlock cycle");

  a_secure_window: assert property (@(posedge mclk) disable iff (sys_rst)
    (go && secure_r && cmd_r == fwpg_pkg::CMD_READ) |-> in_sec)
    else $error("array read while secure region mapped");

  a_supply_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd_wr && !sup_s2_r) |=> (err_r && !go) ##1 !go)
    else $error("command taken below supply lockout");

  a_lock_secure: assert property (@(posedge mclk) disable iff (sys_rst)
    (go && cmd_r == fwpg_pkg::CMD_LOCK) |-> (secure_r && flash_rst_n))
    else $error("lock issued outside secure mapping");

  a_reset_unmaps: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == T_RST) |=> !secure_r ##[1:100] rst_pin_r)
    else $error("hardware reset left mapping or pin low");

endmodule

/* verification/fwpg_flash_model.sv */
// fwpg_flash_model: behavioural flash seen at its pins
// assumes strobes come from the controller under test
`timescale 1ns/10ps
module fwpg_flash_model
(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq,
  output logic [15:0]      dq_in,
  output logic             busy_n
);
  logic [15:0] mem [int];
  logic [15:0] last = 16'h0000;
  // customer-lockable part: indicator reads 0, no serial number field preloaded
  localparam logic LOCKED_AT_FACTORY = 1'b0;
  initial busy_n = 1'b1;
  // write taken on we_n rise only with ce_n low, oe_n high
  always @(posedge we_n)
    if (!ce_n && oe_n)
    begin
      if (last == 16'h00a0 && !LOCKED_AT_FACTORY)
      begin
        mem[addr] = dq;
        busy_n = 1'b0;
        busy_n <= #300 1'b1; // slow program
        last = 16'h0000; // a data word never counts as a command code
      end
      else
        last = dq;
    end
  // released bus shows a changing pattern
  always @*
    dq_in = (!ce_n && !oe_n) ? (mem.exists(addr) ? mem[addr] : 16'hffff) : ~last ^ addr[15:0];
endmodule

/* verification/fwpg_ctrl_tb.sv */
// fwpg_ctrl_tb: register-level test of fwpg_ctrl against a bench model
// assumes fwpg_flash_model on the flash pins
`timescale 1ns/10ps
module fwpg_ctrl_tb;
  logic        mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sup = 1;
  logic [2:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, s;
  logic        ce_n, oe_n, we_n, hv, wp, busy_n, doe, rn;
  logic [20:0] fa;
  logic [15:0] dq, dqi, m [int];
  int          n_fail = 0, total_checks = 0, sec = 0, ctl = 1, a, d;
  always #5 mclk = ~mclk;
  fwpg_ctrl #(.POWERUP_CYC(64)) dut_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(fa), .flash_dq_out(dq), .flash_dq_oe(doe), .flash_dq_in(dqi),
    .flash_rst_n(rn), .flash_hv_en(hv), .write_protect_accel_pin(wp),
    .flash_busy_n(busy_n), .supply_above_lockout(sup));
  // undriven data lines float high at the flash
  fwpg_flash_model fm_u (.ce_n, .oe_n, .we_n, .addr(fa), .dq(doe ? dq : 16'hffff),
    .dq_in(dqi), .busy_n);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    total_checks++;
    if (v !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a[2:0];
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input int a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a[2:0];
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 s = reg_rdata;
  endtask
  // bench model of which commands are refused
  function automatic int exp_err(int c, int a);
    bit pair = ctl[2] ? a >= 'h1fe000 : a <= 'h1fff;
    bit win = ctl[2] ? a >= 'h1f8000 : a <= 'h7fff;
    return c == 7 || !sup || (c inside {1, 2} && pair && !ctl[0] && !sec)
           || (sec && c < 3 && !win) || (c inside {4, 5} && !sec) || (c == 3 && sec);
  endfunction
  task automatic cmd(input int c, input int a, input int d);
    int e;
    wr(1, a);
    e = exp_err(c, a); // taken after two clocks so a supply change has landed
    wr(2, d);
    wr(3, c);
    for (int i = 0; i < 300 && (i == 0 || s[0]); i++)
      rd(4);
    chk("busy", 0, s[0]);
    chk("err", e, s[2]);
    if (!e && c == 1)
      m[a] = d;
    if (!e && c >= 3)
      sec = (c == 3) || (sec && c == 5);
    chk("secure", sec, s[1]);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200000;
    n_fail++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'h8fa478bc));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(0);
    chk("ctrl", 1, s);
    wr(3, 1);
    rd(4);
    chk("early", 'h5, s[3:0]);
    chk("rst_pin", 0, rn);
    repeat (80) @(posedge mclk);
    rd(7);
    chk("unmapped", 0, s);
    for (int i = 0; i < 8; i++)
    begin
      ctl = i;
      wr(0, i);
      rd(0);
      chk("ctrl", i, s);
      chk("wp", i & 1, wp);
      chk("hv", i >> 1 & 1, hv);
      a = i[2] ? 'h1fe000 + $urandom % 'h2000 : $urandom % 'h2000;
      d = $urandom % 'h10000;
      cmd(2, a, 0);
      cmd(1, a, d);
      cmd(0, a, 0);
      rd(5);
      chk("rdata", m.exists(a) ? m[a] : 'hffff, s);
      cmd(1, 'h8000 + $urandom % 'h1f0000, d);
    end
    ctl = 1;
    wr(0, 1);
    cmd(4, 0, 0);
    cmd(3, 0, 0);
    cmd(3, 0, 0);
    cmd(1, 'h100000, 1);
    cmd(1, 'h10, 'h1234);
    cmd(5, 0, 0);
    cmd(4, 0, 0);
    cmd(3, 0, 0);
    cmd(6, 0, 0);
    chk("rst_pin", 1, rn);
    cmd(7, 0, 0);
    @(posedge mclk);
    sup <= 1'b0;
    cmd(1, 'h9000, 5);
    chk("supply", 0, s[4]);
    test_done;
  end
endmodule
